/* File: verilog/sldrv_pkg.sv */
// Package: shared constants and types of the serial latched output driver
package sldrv_pkg;
  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int CHAN_NUM        = 12;
  localparam int SYS_CLK_MHZ     = 125;
  // ---------------------------------------------------------------------
  // Link timing in nanoseconds and derived cycle counts
  // ---------------------------------------------------------------------
  localparam int T_CLK_PERIOD_NS = 1000;
  localparam int T_CLK_PHASE_NS  = 480;
  localparam int T_LATCH_HIGH_NS = 480;
  localparam int T_LATCH_GAP_NS  = 250;
  localparam int T_SETUP_NS      = 150;
  localparam int T_SETTLE_NS     = 300;
  // Least times round up
  localparam int HALF_CYC  = ((T_CLK_PERIOD_NS / 2) * SYS_CLK_MHZ + 999)
                             / 1000;
  localparam int PHASE_CYC = (T_CLK_PHASE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LATH_CYC  = (T_LATCH_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC   = (T_LATCH_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (T_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
  // Longest time rounds down: load to outputs
  localparam int SETTLE_CYC = (T_SETTLE_NS * SYS_CLK_MHZ) / 1000;
  localparam logic [CHAN_NUM-1:0] CHAN_RST = 12'h000;
  // ---------------------------------------------------------------------
  // Controller sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    CT_IDLE, CT_LOW, CT_HIGH, CT_GAP, CT_LATCH
  } sldrv_ct_state_t;
endpackage

/* File: verilog/sldrv_if.sv */
// Interface: the five link wires plus cascade return between both ends
`timescale 1ns/1ps
`default_nettype none
interface sldrv_if;
  logic sclk;
  logic serial_in;
  logic load;
  logic rst_n;
  logic output_kill;
  logic cascade_out;
  modport ctrl (
    output sclk, serial_in, load, rst_n, output_kill,
    input  cascade_out
  );
  modport dev (
    input  sclk, serial_in, load, rst_n, output_kill,
    output cascade_out
  );
endinterface
`default_nettype wire

/* File: verilog/sldrv_sync.sv */
// Two-stage synchroniser with edge detection for link pins
`timescale 1ns/1ps
`default_nettype none
module sldrv_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  // ---------------------------------------------------------------------
  // Only sync_q reads meta_q; edges come from later stages
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* File: verilog/sldrv_device.sv */
// Device end: shift register, holding register, kill gating, cascade out
// Function
// - Shift serial_in on each clock rise
// - Load strobe rise copies shift to holding
// - Holding register stable between load rises
// - Reset low clears both registers
// - Controller holds reset low at power-up
// - Frame sent channel 11 first
// - Channel on when its bit is one
// - Kill high forces all outputs off
// - Kill high disables overtemperature protection
// - Kill may carry PWM gating outputs
// - Cascade out changes on clock fall
// - Twelve clocks per chained device
// - Chained devices share clock, data daisy-chained
// - Clock period 1000 ns, phases 480 ns
// - Data bit stable at least 980 ns
// - Data set up 150 ns before rise
// - Load strobe high at least 480 ns
// - Load rises 250 ns after last rise
// - Outputs follow load within 300 ns
`timescale 1ns/1ps
`default_nettype none
module sldrv_device
  import sldrv_pkg::*;
#(
  parameter int CHANNELS = sldrv_pkg::CHAN_NUM
) (
  input  wire logic                ref_clk_in,
  input  wire logic                rstn_in,
  sldrv_if.dev                     link,
  input  wire logic                overtemp_in,
  output logic      [CHANNELS-1:0] channel_outputs_out,
  output logic      [CHANNELS-1:0] channel_oe_out,
  output logic                     overtemp_protect_out
);
  import sldrv_pkg::*;

  // Elaboration check: the shift path needs at least two stages
  if (CHANNELS < 2) begin : g_chan_check
    $error("CHANNELS must be at least 2");
  end

  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [CHANNELS-1:0] shift_q;
  logic [CHANNELS-1:0] hold_q;
  logic                cas_q;
  logic [CHANNELS-1:0] drive_q;
  logic                pin_rst_n;

  // ---------------------------------------------------------------------
  // Pin sampling: sclk, serial_in, load, output_kill
  // ---------------------------------------------------------------------
  sldrv_sync #(.WIDTH(4)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .async_in   ({link.output_kill, link.load, link.serial_in, link.sclk}),
    .level_out  (lvl),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // Reset pin is combined with local reset without sync so it acts at once
  assign pin_rst_n = rstn_in & link.rst_n;

  // Serial data sampled two cycles late, same as the clock, so aligned
  always_ff @(posedge ref_clk_in) begin
    if (!pin_rst_n) begin
      shift_q <= CHAN_RST;
    end else if (rise[0]) begin
      shift_q <= {shift_q[CHANNELS-2:0], lvl[1]};
    end
  end

  // Holding register only changes on a load rise or a pin reset
  always_ff @(posedge ref_clk_in) begin
    if (!pin_rst_n) begin
      hold_q <= CHAN_RST;
    end else if (rise[2]) begin
      hold_q <= shift_q;
    end
  end

  // Cascade retimed to clock fall for setup margin downstream
  always_ff @(posedge ref_clk_in) begin
    if (!pin_rst_n) begin
      cas_q <= 1'b0;
    end else if (fall[0]) begin
      cas_q <= shift_q[CHANNELS-1];
    end
  end
  assign link.cascade_out = cas_q;

  // Drive: one register stage, well inside the settle limit
  always_ff @(posedge ref_clk_in) begin
    if (!pin_rst_n) begin
      drive_q <= CHAN_RST;
    end else begin
      drive_q <= hold_q & {CHANNELS{~lvl[3]}};
    end
  end

  // Open drain: pull low when on, enable high while driving
  assign channel_outputs_out = '0;
  assign channel_oe_out      = drive_q;

  // Protection only acts when kill is low
  assign overtemp_protect_out = overtemp_in & ~lvl[3];
endmodule
`default_nettype wire

/* File: verilog/sldrv_ctrl.sv */
// Controller end: buffers frames and serialises them onto the link
`timescale 1ns/1ps
`default_nettype none
module sldrv_ctrl
  import sldrv_pkg::*;
#(
  parameter int FRAME_BITS = sldrv_pkg::CHAN_NUM
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  sldrv_if.ctrl                      link,
  input  wire logic [FRAME_BITS-1:0] frame_in,
  input  wire logic                  frame_valid_in,
  output logic                       frame_ready_out,
  input  wire logic                  kill_in,
  output logic                       busy_out
);
  import sldrv_pkg::*;

  // Elaboration check: shifter reads bit FRAME_BITS-2, bit counter is 8 bits
  if (FRAME_BITS < 2 || FRAME_BITS > 255) begin : g_bits_check
    $error("bad FRAME_BITS");
  end

  // ---------------------------------------------------------------------
  // Two-entry buffer: source stalls only when both slots are full
  // ---------------------------------------------------------------------
  logic [FRAME_BITS-1:0] buf_q [2];
  logic                  wr_q;
  logic                  rd_q;
  logic [1:0]            cnt_q;
  logic                  pop;
  logic                  push;
  assign frame_ready_out = (cnt_q != 2'd2);
  assign push = frame_valid_in & frame_ready_out;

  sldrv_ct_state_t state_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [7:0]            bit_q;
  logic [7:0]            tmr_q;
  logic sclk_q, sdat_q, load_q, rstn_q, kill_q;

  assign pop = (state_q == CT_IDLE) && (cnt_q != 2'd0);

  // Buffer storage and pointers
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= frame_in;
        wr_q        <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Reset pin low during local reset so outputs stay off at power-up
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rstn_q <= 1'b0;
      kill_q <= 1'b0;
    end else begin
      rstn_q <= 1'b1;
      kill_q <= kill_in;
    end
  end

  // Serial sequencer: MSB first, timed phases, gap then load pulse
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state_q <= CT_IDLE;
      sh_q    <= '0;
      bit_q   <= 8'h00;
      tmr_q   <= 8'h00;
      sclk_q  <= 1'b0;
      sdat_q  <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      unique case (state_q)
        CT_IDLE: begin
          load_q <= 1'b0;
          if (pop) begin
            sh_q    <= buf_q[rd_q];
            sdat_q  <= buf_q[rd_q][FRAME_BITS-1];
            bit_q   <= 8'(FRAME_BITS - 1);
            tmr_q   <= 8'(HALF_CYC - 1);
            state_q <= CT_LOW;
          end
        end
        CT_LOW: begin
          // Data changes at low start, so setup equals a half period
          if (tmr_q == 8'h00) begin
            sclk_q  <= 1'b1;
            tmr_q   <= 8'(HALF_CYC - 1);
            state_q <= CT_HIGH;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        CT_HIGH: begin
          if (tmr_q == 8'h00) begin
            sclk_q <= 1'b0;
            if (bit_q == 8'h00) begin
              tmr_q   <= 8'(GAP_CYC - 1);
              state_q <= CT_GAP;
            end else begin
              sh_q    <= {sh_q[FRAME_BITS-2:0], 1'b0};
              sdat_q  <= sh_q[FRAME_BITS-2];
              bit_q   <= bit_q - 8'h01;
              tmr_q   <= 8'(HALF_CYC - 1);
              state_q <= CT_LOW;
            end
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        CT_GAP: begin
          if (tmr_q == 8'h00) begin
            load_q  <= 1'b1;
            tmr_q   <= 8'(LATH_CYC - 1);
            state_q <= CT_LATCH;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        CT_LATCH: begin
          if (tmr_q == 8'h00) begin
            load_q  <= 1'b0;
            state_q <= CT_IDLE;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
      endcase
    end
  end

  assign link.sclk        = sclk_q;
  assign link.serial_in   = sdat_q;
  assign link.load        = load_q;
  assign link.rst_n       = rstn_q;
  assign link.output_kill = kill_q;
  assign busy_out         = (state_q != CT_IDLE) || (cnt_q != 2'd0);
endmodule
`default_nettype wire

/* File: test/sldrv_monitor.sv */
// Checker: link timing, cascade and channel relations across both ends
`timescale 1ns/1ps
`default_nettype none
module sldrv_monitor
  import sldrv_pkg::*;
(
  input wire logic                           ref_clk_in,
  input wire logic                           rstn_in,
  input wire logic                           sclk,
  input wire logic                           serial_in,
  input wire logic                           load,
  input wire logic                           rst_n,
  input wire logic                           output_kill,
  input wire logic                           cascade_out,
  input wire logic [sldrv_pkg::CHAN_NUM-1:0] channel_oe_out,
  input wire logic                           overtemp_in,
  input wire logic                           overtemp_protect_out
);
  localparam int SETTLE = SETTLE_CYC;
  logic [11:0] hist_q;
  logic [11:0] hold_q;
  logic [15:0] cs_q;
  logic [15:0] cl_q;
  logic [15:0] ce_q;
  logic        sp_q;
  logic        lp_q;
  logic        kp_q;
  logic [15:0] cd_q;
  logic [15:0] cr_q;
  logic        dp_q;
  // -------------------------------------------------------------------
  // Bit history and quiet-time counters
  // -------------------------------------------------------------------
  // Counters saturate so a long idle never wraps into a false pass
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      {hist_q, hold_q, cs_q, cl_q, ce_q, sp_q, lp_q, kp_q} <= '0;
      {cd_q, cr_q, dp_q} <= '0;
    end else begin
      dp_q <= serial_in;
      // Quiet time of the data line, and time since the last clock rise
      cd_q <= (serial_in != dp_q) ? 16'h0001 : cd_q + {15'h0000, ~&cd_q};
      cr_q <= (sclk && !sp_q) ? 16'h0001 : cr_q + {15'h0000, ~&cr_q};
      sp_q <= sclk;
      lp_q <= load;
      kp_q <= output_kill;
      cs_q <= (sclk != sp_q) ? 16'h0001 : cs_q + {15'h0000, ~&cs_q};
      cl_q <= (load != lp_q) ? 16'h0001 : cl_q + {15'h0000, ~&cl_q};
      ce_q <= ((load && !lp_q) || output_kill != kp_q) ? 16'h0000
              : ce_q + {15'h0000, ~&ce_q};
      if (sclk && !sp_q) begin
        hist_q <= {hist_q[10:0], serial_in};
      end
      if (load && !lp_q) begin
        hold_q <= hist_q;
      end
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_fall; sp_q && !sclk; endsequence
  sequence s_load_rise; load && !lp_q; endsequence
  sequence s_rise; sclk && !sp_q; endsequence
  property p_casc_val; s_fall |-> ##[1:8] cascade_out == hist_q[11];
  endproperty
  a_casc_val: assert property (p_casc_val)
    else $error("cascade bit differs from shifted history");
  property p_casc_quiet; $changed(cascade_out) |-> !sclk && cs_q < 16'd9;
  endproperty
  a_casc_quiet: assert property (p_casc_quiet)
    else $error("cascade changed away from a clock fall");
  property p_load_copy;
    s_load_rise ##0 !output_kill |-> ##[1:SETTLE] channel_oe_out == hist_q;
  endproperty
  a_load_copy: assert property (p_load_copy)
    else $error("channels did not take the frame in time");
  // Kill level of the previous sample: the counter restarts one cycle late
  property p_oe_val;
    ce_q > SETTLE |-> channel_oe_out == (kp_q ? 12'h000 : hold_q);
  endproperty
  a_oe_val: assert property (p_oe_val)
    else $error("channels differ from held frame or kill");
  property p_tsd;
    ce_q > SETTLE |-> overtemp_protect_out == (overtemp_in && !kp_q);
  endproperty
  a_tsd: assert property (p_tsd)
    else $error("overtemp protection not gated by kill");
  property p_rst_clr; !rst_n |=> channel_oe_out == 12'h000 && !cascade_out;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("reset left registers set");
  property p_sclk_ph; sclk != sp_q |-> cs_q >= PHASE_CYC; endproperty
  a_sclk_ph: assert property (p_sclk_ph)
    else $error("link clock phase too short");
  property p_load_hi; lp_q && !load |-> cl_q >= LATH_CYC; endproperty
  a_load_hi: assert property (p_load_hi)
    else $error("load strobe high too short");
  property p_setup; s_rise |-> cd_q >= SETUP_CYC; endproperty
  a_setup: assert property (p_setup)
    else $error("link data changed too close to clock rise");
  property p_gap; s_load_rise |-> cr_q >= GAP_CYC; endproperty
  a_gap: assert property (p_gap)
    else $error("load raised too soon after last clock rise");
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Testbench: controller and device joined, frames checked at channels
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sldrv_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [11:0] frame      = 12'h000;
  logic        valid      = 1'b0;
  logic        kill       = 1'b0;
  logic        hot        = 1'b0;
  logic        ready;
  logic        busy;
  logic        prot;
  logic [11:0] oe;
  int          n_fail     = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  logic [11:0] pats [5]   = '{12'ha5c, 12'h5a3, 12'h800, 12'h001, 12'h0f0};
  sldrv_if link ();
  sldrv_ctrl sldrv_ctrl_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .link(link.ctrl), .frame_in(frame), .frame_valid_in(valid),
    .frame_ready_out(ready), .kill_in(kill), .busy_out(busy));
  sldrv_device sldrv_device_inst (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .link(link.dev), .overtemp_in(hot),
    .channel_outputs_out(), .channel_oe_out(oe),
    .overtemp_protect_out(prot));
  sldrv_monitor sldrv_monitor_inst (.ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in), .sclk(link.sclk), .serial_in(link.serial_in),
    .load(link.load), .rst_n(link.rst_n), .output_kill(link.output_kill),
    .cascade_out(link.cascade_out), .channel_oe_out(oe),
    .overtemp_in(hot), .overtemp_protect_out(prot));
  always #4 ref_clk_in = ~ref_clk_in;
  // Hang guard: twelve frames take about 18300 cycles
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      $display("ERROR %0t run did not finish", $time);
      report_and_stop();
    end
  end
  // -------------------------------------------------------------------
  // Access tasks
  // -------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Ready is looked at on the falling edge, the next rise takes the frame
  task automatic send(input logic [11:0] f);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    frame = f;
    valid = 1'b1;
    while (ready !== 1'b1 && n < 5000) begin
      n++;
      @(negedge ref_clk_in);
    end
    if (n == 5000) begin
      n_fail++;
      $display("ERROR %0t frame never accepted", $time);
    end
    @(negedge ref_clk_in);
    valid = 1'b0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    pause(4);
    while (busy !== 1'b0 && n < 10000) begin
      n++;
      @(negedge ref_clk_in);
    end
    if (n == 10000) begin
      n_fail++;
      $display("ERROR %0t controller stayed busy", $time);
    end
    pause(8);
  endtask
  initial begin
    pause(6);
    rstn_in = 1'b1;
    pause(2);
    chk(oe, 12'h000);
    foreach (pats[i]) begin
      send(pats[i]);
      idle();
      chk(oe, pats[i]);
    end
    // Three frames at once fill the buffer; outputs hold meanwhile
    send(12'h3c3);
    send(12'h999);
    send(12'hc3c);
    chk({11'h000, ready}, 12'h000);
    chk(oe, 12'h0f0);
    send(12'hb46);
    idle();
    chk(oe, 12'hb46);
    chk({11'h000, link.cascade_out}, 12'h001);
    hot = 1'b1;
    for (int i = 0; i < 3; i++) begin
      kill = 1'b1;
      pause(SETTLE_CYC);
      chk(oe, 12'h000);
      chk({11'h000, prot}, 12'h000);
      kill = 1'b0;
      pause(SETTLE_CYC);
      chk(oe, 12'hb46);
      chk({11'h000, prot}, 12'h001);
    end
    kill = 1'b1;
    send(12'h7e1);
    idle();
    chk(oe, 12'h000);
    kill = 1'b0;
    pause(SETTLE_CYC);
    chk(oe, 12'h7e1);
    // Reset in mid-frame, then resume with no extra set-up
    send(12'hfff);
    pause(300);
    rstn_in = 1'b0;
    pause(6);
    rstn_in = 1'b1;
    pause(2);
    chk(oe, 12'h000);
    send(12'h2d5);
    idle();
    chk(oe, 12'h2d5);
    report_and_stop();
  end
endmodule
`default_nettype wire
